/* File: logic/scs_pkg.sv */
package scs_pkg;
  // byte addresses of the register words
  localparam logic [7:0] SCS_SYS_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] SCS_FAST_RC_ADDR    = 8'h04;
  localparam logic [7:0] SCS_FAST_XTAL_ADDR  = 8'h08;
  localparam logic [7:0] SCS_SLOW_XTAL_ADDR  = 8'h0c;
  localparam logic [7:0] SCS_STATUS_ADDR     = 8'h10;

  // system_clock_ctrl fields
  localparam int SCS_DIV_LSB     = 5;
  localparam int SCS_HF_SEL_BIT  = 3;
  localparam int SCS_LF_SEL_BIT  = 2;
  localparam int SCS_HF_IDLE_BIT = 1;
  localparam int SCS_LF_IDLE_BIT = 0;
  // oscillator control fields
  localparam int SCS_FREQ_LSB    = 2;
  localparam int SCS_PIN_SEL_BIT = 2;
  localparam int SCS_READY_BIT   = 1;
  localparam int SCS_EN_BIT      = 0;
  // status fields
  localparam int SCS_ST_HF_BIT   = 3;
  localparam int SCS_ST_LF_BIT   = 4;
  localparam int SCS_ST_MISM_BIT = 5;

  localparam logic [2:0] SCS_DIV_SUB = 3'h7;
  localparam logic [2:0] SCS_DIV_RST = 3'h0;
  localparam logic [1:0] SCS_FREQ_RST = 2'h0;

  // fast_rc_freq_sel codes
  localparam logic [1:0] SCS_FREQ_8M  = 2'h0;
  localparam logic [1:0] SCS_FREQ_12M = 2'h1;
  localparam logic [1:0] SCS_FREQ_16M = 2'h2;

  // crystal start-up, counted in ticks of the crystal itself
  localparam int SCS_FAST_XTAL_START_TICKS = 1024;
  localparam int SCS_SLOW_XTAL_START_TICKS = 1024;
  localparam int SCS_START_CNT_W           = 16;

  localparam int SCS_DIV_CNT_W = 6;
endpackage

/* File: logic/scs_clock_select.sv */
// Summary of operation
// - high clock comes from internal fast RC or external fast crystal.
// - fast RC frequency 8, 12 or 16 MHz fixed by a build option.
// - slow crystal at 32.768kHz is one low clock choice via lf_source_sel.
// - enabling slow crystal starts it; unusable until start-up delay passes.
// - pin-share bit set with slow crystal enabled gives crystal use of crystal pins, otherwise general use.
// - internal slow RC at nominal 32kHz is the other low clock choice.
// - sub clock comes from slow crystal or slow RC per lf_source_sel.
// - system clock is high clock, divided high clock or sub clock.
// - divider offers high clock divided by two up to sixty-four.
// - on sub clock, fast oscillator stops or runs per its enable bit.
// - halted, system clock gated; independent clock keeps timers running.
// - divider code 000 undivided, each step doubles, 111 sub clock.
// - hf_source_sel 0 picks fast RC, 1 picks fast crystal.
// - lf_source_sel 0 picks slow RC, 1 picks slow crystal.
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select
  import scs_pkg::*;
#(
  parameter int FAST_RC_MHZ      = 16,
  parameter int FAST_XTAL_START  = SCS_FAST_XTAL_START_TICKS,
  parameter int SLOW_XTAL_START  = SCS_SLOW_XTAL_START_TICKS
) (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  input  wire logic        fast_rc_tick_in,
  input  wire logic        fast_xtal_tick_in,
  input  wire logic        slow_rc_tick_in,
  input  wire logic        slow_xtal_tick_in,
  input  wire logic        cpu_halt_in,
  output logic             fast_rc_run_out,
  output logic             fast_xtal_run_out,
  output logic             slow_rc_run_out,
  output logic             slow_xtal_run_out,
  output logic             slow_crystal_pins_osc_out,
  output logic             system_clock_tick_out,
  output logic             high_clock_tick_out,
  output logic             sub_clock_tick_out
);

  if (FAST_RC_MHZ != 8 && FAST_RC_MHZ != 12 &&
      FAST_RC_MHZ != 16) begin : g_chk_f
    $error("FAST_RC_MHZ must be 8, 12 or 16");
  end
  if (FAST_XTAL_START < 1 || FAST_XTAL_START >= (1 << SCS_START_CNT_W) ||
      SLOW_XTAL_START < 1 || SLOW_XTAL_START >= (1 << SCS_START_CNT_W))
  begin : g_chk_s
    $error("crystal start-up counts out of range");
  end
  if (SCS_DIV_CNT_W < 6) begin : g_chk_d
    $error("divider counter too narrow for division by 64");
  end

  localparam logic [1:0] FREQ_EXPECT =
    (FAST_RC_MHZ == 8)  ? SCS_FREQ_8M :
    (FAST_RC_MHZ == 12) ? SCS_FREQ_12M : SCS_FREQ_16M;

  // tick of divided high clock for a divider code and counter value
  function automatic logic div_hit(input logic [2:0] sel,
                                   input logic [SCS_DIV_CNT_W-1:0] cnt);
    logic [SCS_DIV_CNT_W-1:0] mask;
    mask = SCS_DIV_CNT_W'((1 << sel) - 1);
    div_hit = ((cnt & mask) == mask);
  endfunction

  // one-hot register select: sys, fast rc, fast xtal, slow xtal, status
  function automatic logic [4:0] reg_dec(input logic [7:0] addr);
    reg_dec = {(addr == SCS_STATUS_ADDR),
               (addr == SCS_SLOW_XTAL_ADDR),
               (addr == SCS_FAST_XTAL_ADDR),
               (addr == SCS_FAST_RC_ADDR),
               (addr == SCS_SYS_CTRL_ADDR)};
  endfunction

  // software controls
  logic [2:0] div_sel_r;
  logic       hf_sel_r;
  logic       lf_sel_r;
  logic       hf_idle_r;
  logic       lf_idle_r;
  logic [1:0] freq_sel_r;
  logic       rc_en_r;
  logic       fx_en_r;
  logic       sx_en_r;
  logic       pin_sel_r;
  // selection actually in force
  logic [2:0] div_act_r;
  logic       hf_act_r;
  logic       lf_act_r;
  logic [SCS_DIV_CNT_W-1:0] div_cnt_r;
  logic       sub_skip_r;
  // bus state
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic       rd_pend_r;
  logic [7:0] rd_addr_r;

  // crystal start-up: index 0 fast crystal, 1 slow crystal
  logic [1:0] xt_en;
  logic [1:0] xt_tick;
  logic [1:0] xt_ready;
  assign xt_en   = {sx_en_r, fx_en_r};
  assign xt_tick = {slow_xtal_tick_in, fast_xtal_tick_in};

  for (genvar i = 0; i < 2; i++) begin : g_xtal
    localparam logic [SCS_START_CNT_W-1:0] START =
      SCS_START_CNT_W'((i == 0) ? FAST_XTAL_START : SLOW_XTAL_START);
    logic [SCS_START_CNT_W-1:0] cnt_r;
    logic                       rdy_r;
    always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
        cnt_r <= '0;
        rdy_r <= 1'b0;
      end else if (!xt_en[i]) begin
        cnt_r <= '0;
        rdy_r <= 1'b0;
      end else if (xt_tick[i] && !rdy_r) begin
        cnt_r <= cnt_r + 1'b1;
        rdy_r <= (cnt_r == START - 1'b1);
      end
    end
    assign xt_ready[i] = rdy_r;
  end

  // clock paths
  wire fx_usable  = xt_ready[0] & fast_xtal_tick_in;
  wire sx_usable  = xt_ready[1] & slow_xtal_tick_in;
  wire high_tick  = hf_act_r ? fx_usable : fast_rc_tick_in;
  wire sub_tick   = lf_act_r ? sx_usable :
                    slow_rc_tick_in;
  wire on_sub     = (div_act_r == SCS_DIV_SUB);
  wire div_tick   = high_tick & div_hit(div_act_r, div_cnt_r);
  wire src_tick   = on_sub ? (sub_tick & !sub_skip_r) :
                    div_tick;
  // a pending selection takes force at the end of a full period
  wire sel_chg    = (div_sel_r != div_act_r) | (hf_sel_r != hf_act_r) |
                    (lf_sel_r != lf_act_r);
  wire sw_now     = src_tick & sel_chg;
  wire need_high  = (!cpu_halt_in & !on_sub) | (cpu_halt_in & hf_idle_r);
  wire need_sub   = !cpu_halt_in | lf_idle_r;
  wire freq_mism  = (freq_sel_r != FREQ_EXPECT);

  // bus decode
  wire        addr_ok  = hsel_in & htrans_in[1] & hready_in;
  wire [7:0]  addr_lo  = {haddr_in[7:2], 2'b00};
  wire [4:0]  wr_hit   = wr_pend_r ? reg_dec(wr_addr_r) : 5'h00;
  wire [4:0]  rd_hit   = reg_dec(rd_addr_r);
  wire        wr_sys   = wr_hit[0];
  wire        wr_rc    = wr_hit[1];
  wire        wr_fx    = wr_hit[2];
  wire        wr_sx    = wr_hit[3];
  wire [7:0]  rd_sys   = {div_sel_r, 1'b0, hf_sel_r, lf_sel_r,
                          hf_idle_r, lf_idle_r};
  wire [7:0]  rd_rc    = {4'h0, freq_sel_r, fast_rc_run_out, rc_en_r};
  wire [7:0]  rd_fx    = {6'h00, xt_ready[0], fx_en_r};
  wire [7:0]  rd_sx    = {5'h00, pin_sel_r, xt_ready[1], sx_en_r};
  wire [7:0]  rd_st    = {2'h0, freq_mism, lf_act_r, hf_act_r, div_act_r};
  wire [7:0]  rd_val   = rd_hit[0] ? rd_sys :
                         rd_hit[1] ? rd_rc  :
                         rd_hit[2] ? rd_fx  :
                         rd_hit[3] ? rd_sx  :
                         rd_hit[4] ? rd_st  : 8'h00;

  // write data phase follows its address phase by one cycle
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok & hwrite_in;
      wr_addr_r <= addr_lo;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_pend_r     <= 1'b0;
      rd_addr_r     <= 8'h00;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      hrdata_out    <= 32'h0000_0000;
    end else begin
      if (rd_pend_r) begin
        rd_pend_r     <= 1'b0;
        hreadyout_out <= 1'b1;
        hrdata_out    <= {24'h000000, rd_val};
      end else if (addr_ok && !hwrite_in) begin
        // one wait state so a write just before is seen
        rd_pend_r     <= 1'b1;
        rd_addr_r     <= addr_lo;
        hreadyout_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_sel_r  <= SCS_DIV_RST;
      hf_sel_r   <= 1'b0;
      lf_sel_r   <= 1'b0;
      hf_idle_r  <= 1'b0;
      lf_idle_r  <= 1'b0;
      freq_sel_r <= SCS_FREQ_RST;
      rc_en_r    <= 1'b1;
      fx_en_r    <= 1'b0;
      sx_en_r    <= 1'b0;
      pin_sel_r  <= 1'b0;
    end else begin
      if (wr_sys) begin
        div_sel_r <= hwdata_in[SCS_DIV_LSB +: 3];
        hf_sel_r  <= hwdata_in[SCS_HF_SEL_BIT];
        lf_sel_r  <= hwdata_in[SCS_LF_SEL_BIT];
        hf_idle_r <= hwdata_in[SCS_HF_IDLE_BIT];
        lf_idle_r <= hwdata_in[SCS_LF_IDLE_BIT];
      end
      if (wr_rc) begin
        freq_sel_r <= hwdata_in[SCS_FREQ_LSB +: 2];
        rc_en_r    <= hwdata_in[SCS_EN_BIT];
      end
      if (wr_fx) begin
        fx_en_r <= hwdata_in[SCS_EN_BIT];
      end
      if (wr_sx) begin
        sx_en_r   <= hwdata_in[SCS_EN_BIT];
        pin_sel_r <= hwdata_in[SCS_PIN_SEL_BIT];
      end
    end
  end

  // selection changes only at the end of a full output period
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_act_r <= SCS_DIV_RST;
      hf_act_r  <= 1'b0;
      lf_act_r  <= 1'b0;
    end else if (sw_now) begin
      div_act_r <= div_sel_r;
      hf_act_r  <= hf_sel_r;
      lf_act_r  <= lf_sel_r;
    end
  end

  // restart the divider so the first new period is a whole one
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_cnt_r <= '0;
    end else if (sw_now) begin
      div_cnt_r <= '0;
    end else if (high_tick) begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  // into sub clock: drop the first sub tick, it may come too soon
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sub_skip_r <= 1'b0;
    end else if (sw_now) begin
      sub_skip_r <= (div_sel_r == SCS_DIV_SUB);
    end else if (on_sub && sub_tick) begin
      sub_skip_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      fast_rc_run_out           <= 1'b1;
      fast_xtal_run_out         <= 1'b0;
      slow_rc_run_out           <= 1'b1;
      slow_xtal_run_out         <= 1'b0;
      slow_crystal_pins_osc_out <= 1'b0;
      system_clock_tick_out     <= 1'b0;
      high_clock_tick_out       <= 1'b0;
      sub_clock_tick_out        <= 1'b0;
    end else begin
      fast_rc_run_out   <= (rc_en_r & !cpu_halt_in) |
                           (!hf_act_r & need_high);
      fast_xtal_run_out <= (fx_en_r & !cpu_halt_in) |
                           (hf_act_r & need_high);
      slow_rc_run_out   <= need_sub | !lf_act_r;
      slow_xtal_run_out <= sx_en_r;
      slow_crystal_pins_osc_out <= pin_sel_r & sx_en_r;
      system_clock_tick_out <= src_tick & !cpu_halt_in;
      high_clock_tick_out   <= high_tick & (!cpu_halt_in | hf_idle_r);
      sub_clock_tick_out    <= sub_tick & need_sub;
    end
  end

endmodule
`default_nettype wire

/* File: tb/scs_clock_select_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select_chk (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic       hwrite_in,
  input wire logic       hready_in,
  input wire logic       hreadyout_out,
  input wire logic       hresp_out,
  input wire logic       fast_rc_tick_in,
  input wire logic       fast_xtal_tick_in,
  input wire logic       slow_rc_tick_in,
  input wire logic       slow_xtal_tick_in,
  input wire logic       cpu_halt_in,
  input wire logic       slow_xtal_run_out,
  input wire logic       slow_crystal_pins_osc_out,
  input wire logic       system_clock_tick_out,
  input wire logic       high_clock_tick_out,
  input wire logic       sub_clock_tick_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  wire taken = hsel_in & htrans_in[1] & hready_in;
  a_read_wait: assert property (
    taken & !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");
  a_write_fast: assert property (taken & hwrite_in |=> hreadyout_out)
    else $error("write stalled");
  a_resp_okay: assert property (hresp_out == 1'b0)
    else $error("response not okay");
  a_halt_gates: assert property (
    cpu_halt_in && $past(cpu_halt_in) |-> !system_clock_tick_out)
    else $error("system tick while halted");
  a_sys_src: assert property (system_clock_tick_out |-> $past(
    fast_rc_tick_in | fast_xtal_tick_in | slow_rc_tick_in | slow_xtal_tick_in))
    else $error("system tick without source");
  a_high_src: assert property (
    high_clock_tick_out |-> $past(fast_rc_tick_in | fast_xtal_tick_in))
    else $error("high tick without fast source");
  a_sub_src: assert property (
    sub_clock_tick_out |-> $past(slow_rc_tick_in | slow_xtal_tick_in))
    else $error("sub tick without slow source");
  a_pins_need: assert property (
    slow_crystal_pins_osc_out |-> slow_xtal_run_out)
    else $error("pins on crystal while disabled");
endmodule
`default_nettype wire

/* File: tb/tb_scs_clock_select.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_scs_clock_select;
  import scs_pkg::*;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0]  htrans_in = 2'h0;
  logic        hwrite_in = 1'b0;
  logic [2:0]  hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h0;
  logic        fast_rc_tick_in = 1'b1;
  logic        fast_xtal_tick_in = 1'b0;
  logic        slow_rc_tick_in = 1'b0;
  logic        slow_xtal_tick_in = 1'b0;
  logic        cpu_halt_in = 1'b0;
  logic [31:0] ns, nh, nb;
  int          failures = 0, check_count = 0, cyc = 0;
  wire logic   hreadyout_out, hresp_out, fast_rc_run_out, fast_xtal_run_out;
  wire logic   slow_rc_run_out, slow_xtal_run_out, slow_crystal_pins_osc_out;
  wire logic   system_clock_tick_out, high_clock_tick_out, sub_clock_tick_out;
  wire logic [31:0] hrdata_out;
  wire logic   hready_in = hreadyout_out;
  scs_clock_select #(.FAST_XTAL_START(4), .SLOW_XTAL_START(4)) dut_u (.*);
  always #25 clk_in = ~clk_in;
  // oscillator ticks: fast crystal /2, slow crystal /4, slow rc /8
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    fast_xtal_tick_in <= cyc[0];
    slow_xtal_tick_in <= cyc[1:0] == 2'h0;
    slow_rc_tick_in <= cyc[2:0] == 3'h0;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wt;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    {hsel_in, htrans_in, hwrite_in, haddr_in} <= {3'b110, w, 24'h0, a};
    wt();
    {hsel_in, htrans_in, hwdata_in} <= {3'b000, d};
    wt();
    q = hrdata_out;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e,
                     input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q & m);
  endtask
  task automatic meas(input int n);
    {ns, nh, nb} = '0;
    repeat (n) begin
      @(posedge clk_in);
      ns += system_clock_tick_out;
      nh += high_clock_tick_out;
      nb += sub_clock_tick_out;
    end
  endtask
  task automatic t_reg;
    chk("fast_rc_run", 1, fast_rc_run_out);
    chk("slow_rc_run", 1, slow_rc_run_out);
    chk("slow_xtal_run", 0, slow_xtal_run_out);
    rdc(SCS_SYS_CTRL_ADDR, 32'hff, 32'h00, "sys_ctrl");
    rdc(SCS_FAST_RC_ADDR, 32'h0d, 32'h01, "fast_rc_ctrl");
    rdc(SCS_SLOW_XTAL_ADDR, 32'hff, 32'h00, "slow_ctrl");
    wr(8'h20, 32'hff);
    rdc(8'h20, 32'hff, 32'h00, "unmapped");
    wr(SCS_STATUS_ADDR, 32'hff);
    rdc(SCS_STATUS_ADDR, 32'h3f, 32'h20, "freq_mismatch");
    wr(SCS_FAST_RC_ADDR, 32'h09);
    rdc(SCS_STATUS_ADDR, 32'h20, 32'h00, "freq_match");
    $display("t_reg done");
  endtask
  task automatic t_div;
    for (int n = 0; n < 7; n++) begin
      wr(SCS_SYS_CTRL_ADDR, 32'(n) << SCS_DIV_LSB);
      repeat (80) @(posedge clk_in);
      rdc(SCS_STATUS_ADDR, 32'h07, 32'(n), "active_div");
      meas(128);
      chk("div_ticks", 32'd128 >> n, ns);
    end
    $display("t_div done");
  endtask
  task automatic t_sub;
    wr(SCS_SYS_CTRL_ADDR, 32'he0);
    repeat (80) @(posedge clk_in);
    meas(128);
    chk("sub_ticks", 16, ns);
    wr(SCS_FAST_RC_ADDR, 32'h08);
    repeat (4) @(posedge clk_in);
    chk("fast_rc_stop", 0, fast_rc_run_out);
    wr(SCS_FAST_RC_ADDR, 32'h09);
    repeat (4) @(posedge clk_in);
    chk("fast_rc_keep", 1, fast_rc_run_out);
    $display("t_sub done");
  endtask
  task automatic gap_chk(input logic [31:0] v, input int lim);
    int last, gmin;
    last = -1;
    gmin = 1000;
    wr(SCS_SYS_CTRL_ADDR, v);
    for (int i = 0; i < 120; i++) begin
      @(posedge clk_in);
      if (system_clock_tick_out === 1'b1) begin
        if (last >= 0 && i - last < gmin) gmin = i - last;
        last = i;
      end
    end
    chk("min_tick_gap", 1, gmin >= lim && gmin < 1000);
  endtask
  task automatic t_glitch;
    gap_chk(32'hc0, 8);
    gap_chk(32'he0, 8);
    $display("t_glitch done");
  endtask
  task automatic t_lxt;
    wr(SCS_SYS_CTRL_ADDR, 32'he4);
    repeat (40) @(posedge clk_in);
    meas(64);
    chk("dead_xtal", 0, ns);
    wr(SCS_SLOW_XTAL_ADDR, 32'h05);
    rdc(SCS_SLOW_XTAL_ADDR, 32'h02, 32'h00, "not_ready");
    chk("pins_osc", 1, slow_crystal_pins_osc_out);
    chk("slow_xtal_on", 1, slow_xtal_run_out);
    repeat (40) @(posedge clk_in);
    rdc(SCS_SLOW_XTAL_ADDR, 32'h07, 32'h07, "xtal_ready");
    meas(128);
    chk("xtal_ticks", 32, ns);
    wr(SCS_SYS_CTRL_ADDR, 32'he0);
    repeat (20) @(posedge clk_in);
    wr(SCS_SLOW_XTAL_ADDR, 32'h04);
    repeat (2) @(posedge clk_in);
    chk("pins_io", 0, slow_crystal_pins_osc_out);
    $display("t_lxt done");
  endtask
  task automatic t_hxt;
    wr(SCS_FAST_XTAL_ADDR, 32'h01);
    repeat (20) @(posedge clk_in);
    wr(SCS_SYS_CTRL_ADDR, 32'h08);
    repeat (40) @(posedge clk_in);
    rdc(SCS_STATUS_ADDR, 32'h0f, 32'h08, "active_hf");
    meas(128);
    chk("hxt_ticks", 64, ns);
    chk("hxt_run", 1, fast_xtal_run_out);
    $display("t_hxt done");
  endtask
  task automatic t_halt;
    wr(SCS_SYS_CTRL_ADDR, 32'h02);
    repeat (40) @(posedge clk_in);
    cpu_halt_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    meas(64);
    chk("halt_sys", 0, ns);
    chk("idle_high", 64, nh);
    chk("idle_sub_off", 0, nb);
    wr(SCS_SYS_CTRL_ADDR, 32'h01);
    repeat (20) @(posedge clk_in);
    meas(64);
    chk("idle_high_off", 0, nh);
    chk("idle_sub", 8, nb);
    chk("fast_rc_halt", 0, fast_rc_run_out);
    cpu_halt_in <= 1'b0;
    $display("t_halt done");
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    t_reg();
    t_div();
    t_sub();
    t_glitch();
    t_lxt();
    t_hxt();
    t_halt();
    complete_run();
  end
endmodule
bind scs_clock_select scs_clock_select_chk chk_u (.*);
`default_nettype wire
